// file: ros_pkg.sv
// Shared constants, types and register map of the receive overrun statistics block
package ros_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_START_OVR  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MIDDLE_OVR = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DESC_OVR   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_MAC_LO     = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MAC_HI     = 8'h18;
  localparam logic [ADDR_W-1:0] REG_MAX_LEN    = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_MCAST_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] MCAST_STRIDE   = 8'h08;

  // Field positions
  localparam int CTRL_PROMISC_BIT     = 0;
  localparam int CTRL_FULL_DUPLEX_BIT = 1;
  localparam int MCAST_VALID_BIT      = 16;

  // Values after reset
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam logic [15:0] MAX_LEN_RESET = 16'h05EE;
  localparam logic [47:0] MAC_RESET     = 48'h0;

  // Timing at the 125 MHz system clock, times in ns
  localparam int CLK_PERIOD_NS = 8;
  localparam int JAM_NS        = 320;
  localparam int SLOT_NS       = 5120;
  localparam int IFG_NS        = 960;
  localparam int JAM_CYCLES    = (JAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_CYCLES   = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IFG_CYCLES    = (IFG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BACKOFF_EXP_MAX = 10;

  // Receive framing
  localparam logic [3:0] SFD_NIBBLE = 4'hD;
  localparam logic [3:0] DA_NIBBLES = 4'hC;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Receive nibble from the PHY
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } ros_mii_rx_t;

  // Buffer resources seen by the receive path
  typedef struct packed {
    logic fifo_full;
    logic buf_avail;
    logic head_desc_zero;
  } ros_rsrc_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_PRE  = 2'b01,
    RX_BODY = 2'b10
  } ros_rx_state_t;

  typedef enum logic [2:0] {
    TX_IDLE    = 3'b000,
    TX_DEFER   = 3'b001,
    TX_SEND    = 3'b010,
    TX_JAM     = 3'b011,
    TX_BACKOFF = 3'b100
  } ros_tx_state_t;

endpackage

// file: ros_event_counter.sv
// Wrapping event counter, one step per pulse
`timescale 1ns/1ns
module ros_event_counter #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Event and value
  input  wire logic             inc,
  output logic      [WIDTH-1:0] count
);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count <= '0;
    else if (inc)
      count <= count + 1'b1;
  end

endmodule

// file: ros_addr_filter.sv
// Destination address classifier and accept decision
`timescale 1ns/1ns
module ros_addr_filter #(
  parameter int ENTRIES = 4
) (
  // Address under test, first byte in bits 7:0
  input  wire logic [47:0]         dest_addr,
  // Station and group list
  input  wire logic [47:0]         station_addr,
  input  wire logic [ENTRIES*48-1:0] mcast_addr,
  input  wire logic [ENTRIES-1:0]  mcast_valid,
  input  wire logic                promisc,
  // Result
  output logic                     accept,
  output logic                     is_broadcast,
  output logic                     is_multicast
);

  logic list_hit;

  always_comb
  begin
    list_hit = 1'b0;
    for (int i = 0; i < ENTRIES; i++)
      if (mcast_valid[i] && mcast_addr[i*48 +: 48] == dest_addr)
        list_hit = 1'b1;
    is_broadcast = &dest_addr;
    is_multicast = dest_addr[0] && !is_broadcast;
    accept = promisc
           || is_broadcast
           || (is_multicast && list_hit)
           || (!dest_addr[0] && dest_addr == station_addr);
  end

endmodule

// file: ros_top.sv
// Receive overrun statistics with address filter, duplex transmit gate and register slave
//
// Contract
// - An accepted frame that cannot start for lack of FIFO space or a DMA buffer bumps the start counter.
// - An accepted frame that starts cleanly but later runs short of resources bumps the middle counter.
// - An accepted frame that meets a zero head descriptor at start or mid-frame bumps the DMA counter; a mid-frame one counts only if no shortage came first.
// - Only frames passing unicast, broadcast or multicast match, or taken in promiscuous mode, count.
// - Frame length never gates the counters, runts and oversize frames count too.
// - CRC, alignment and code errors neither cause nor block a count.
// - An all-ones destination is broadcast, a class apart from multicast.
// - A destination whose first byte has its low bit set is a group address.
// - With promiscuous mode on, frames for other stations are accepted.
// - In full duplex the transmitter never defers and ignores receive activity.
// - In half duplex the transmitter waits for a quiet medium before sending.
// - In half duplex a collision is followed by a fixed jam, then a random backoff, then a retry.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module ros_top
  import ros_pkg::*;
#(
  parameter int MCAST_ENTRIES = 4
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // MII pins
  input  wire logic              mii_rx_clk,
  input  wire ros_mii_rx_t       mii_rx,
  input  wire logic              mii_crs,
  input  wire logic              mii_col,
  // Receive resources, same clock
  input  wire ros_rsrc_t         rsrc,
  // Transmit path, same clock
  input  wire logic              tx_req,
  input  wire logic              tx_done,
  output logic                   tx_grant,
  output logic                   tx_jam,
  output logic                   tx_backoff
);

  // Pin synchronisers
  logic        rclk_s1, rclk_s2, rclk_s3;
  ros_mii_rx_t mii_s1, mii_s2;
  logic        crs_s1, crs_s2, col_s1, col_s2;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {rclk_s1, rclk_s2, rclk_s3} <= 3'h0;
      mii_s1 <= '0;
      mii_s2 <= '0;
      {crs_s1, crs_s2, col_s1, col_s2} <= 4'h0;
    end
    else
    begin
      rclk_s1 <= mii_rx_clk;
      rclk_s2 <= rclk_s1;
      rclk_s3 <= rclk_s2;
      mii_s1  <= mii_rx;
      mii_s2  <= mii_s1;
      crs_s1  <= mii_crs;
      crs_s2  <= crs_s1;
      col_s1  <= mii_col;
      col_s2  <= col_s1;
    end
  end

  logic rx_edge;
  assign rx_edge = rclk_s2 && !rclk_s3;

  // Software registers
  logic [1:0]  ctrl_reg;
  logic [47:0] mac_reg;
  logic [15:0] max_len_reg;
  logic [47:0] mcast_reg [MCAST_ENTRIES];
  logic [MCAST_ENTRIES-1:0] mcast_valid_reg;
  localparam int ENTRIES_FLAT = MCAST_ENTRIES * 48;
  logic [ENTRIES_FLAT-1:0]  mcast_flat;

  always_comb
  begin
    for (int i = 0; i < MCAST_ENTRIES; i++)
      mcast_flat[i*48 +: 48] = mcast_reg[i];
  end

  // Receive classification
  ros_rx_state_t rx_state_reg;
  logic [47:0]   da_reg;
  logic [3:0]    nib_cnt_reg;
  logic          da_done_reg, start_ovr_reg, mid_ovr_reg, desc_cause_reg;
  logic          start_inc_reg, mid_inc_reg, desc_inc_reg;
  logic          accept, is_bcast, is_mcast, short_now;

  ros_addr_filter #(
    .ENTRIES      (MCAST_ENTRIES)
  ) u_filter (
    .dest_addr    (da_reg),
    .station_addr (mac_reg),
    .mcast_addr   (mcast_flat),
    .mcast_valid  (mcast_valid_reg),
    .promisc      (ctrl_reg[CTRL_PROMISC_BIT]),
    .accept       (accept),
    .is_broadcast (is_bcast),
    .is_multicast (is_mcast)
  );

  // Error nibbles are not looked at: line errors never touch the tally
  assign short_now = rsrc.fifo_full || !rsrc.buf_avail || rsrc.head_desc_zero;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_state_reg   <= RX_IDLE;
      da_reg         <= 48'h0;
      nib_cnt_reg    <= 4'h0;
      da_done_reg    <= 1'b0;
      start_ovr_reg  <= 1'b0;
      mid_ovr_reg    <= 1'b0;
      desc_cause_reg <= 1'b0;
    end
    else if (rx_edge)
    begin
      case (rx_state_reg)
        RX_IDLE:
          if (mii_s2.dv)
            rx_state_reg <= RX_PRE;
        RX_PRE:
          if (!mii_s2.dv)
            rx_state_reg <= RX_IDLE;
          else if (mii_s2.d == SFD_NIBBLE)
          begin
            rx_state_reg   <= RX_BODY;
            da_reg         <= 48'h0;
            nib_cnt_reg    <= 4'h0;
            da_done_reg    <= 1'b0;
            start_ovr_reg  <= short_now;
            mid_ovr_reg    <= 1'b0;
            desc_cause_reg <= rsrc.head_desc_zero;
          end
        RX_BODY:
          if (!mii_s2.dv)
            rx_state_reg <= RX_IDLE;
          else
          begin
            if (!da_done_reg)
            begin
              da_reg[nib_cnt_reg*4 +: 4] <= mii_s2.d;
              nib_cnt_reg <= nib_cnt_reg + 4'h1;
              da_done_reg <= (nib_cnt_reg == DA_NIBBLES - 4'h1);
            end
            // First shortage only, so a frame lands in the start or middle bin, never both
            if (!start_ovr_reg && !mid_ovr_reg && short_now)
            begin
              mid_ovr_reg    <= 1'b1;
              desc_cause_reg <= rsrc.head_desc_zero;
            end
          end
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Frame end tally; length is never consulted
  logic frame_end, counted;
  assign frame_end = rx_edge && rx_state_reg == RX_BODY && !mii_s2.dv;
  assign counted   = frame_end && accept
                   && (da_done_reg || ctrl_reg[CTRL_PROMISC_BIT]);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      {start_inc_reg, mid_inc_reg, desc_inc_reg} <= 3'h0;
    else
    begin
      start_inc_reg <= counted && start_ovr_reg;
      mid_inc_reg   <= counted && !start_ovr_reg && mid_ovr_reg;
      desc_inc_reg  <= counted && (start_ovr_reg || mid_ovr_reg)
                     && desc_cause_reg;
    end
  end

  logic [31:0] start_cnt, mid_cnt, desc_cnt;

  ros_event_counter #(.WIDTH(32)) u_start_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (start_inc_reg),
    .count (start_cnt)
  );

  ros_event_counter #(.WIDTH(32)) u_mid_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (mid_inc_reg),
    .count (mid_cnt)
  );

  ros_event_counter #(.WIDTH(32)) u_desc_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (desc_inc_reg),
    .count (desc_cnt)
  );

  // Transmit medium access
  ros_tx_state_t tx_state_reg;
  logic [15:0]   tmr_reg;
  logic [9:0]    slots_reg;
  logic [3:0]    attempt_reg;
  logic [15:0]   lfsr_reg;
  logic [9:0]    bo_mask;
  logic          full_dup;

  assign full_dup = ctrl_reg[CTRL_FULL_DUPLEX_BIT];
  assign bo_mask  = (attempt_reg >= 4'(BACKOFF_EXP_MAX - 1)) ? 10'h3FF
                  : 10'((11'h2 << attempt_reg) - 11'h1);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lfsr_reg <= 16'hACE1;
    else
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_state_reg <= TX_IDLE;
      tmr_reg      <= 16'h0;
      slots_reg    <= 10'h0;
      attempt_reg  <= 4'h0;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          attempt_reg <= 4'h0;
          tmr_reg     <= 16'h0;
          if (tx_req)
            tx_state_reg <= full_dup ? TX_SEND : TX_DEFER;
        end
        TX_DEFER:
          if (full_dup)
            tx_state_reg <= TX_SEND;
          else if (crs_s2)
            tmr_reg <= 16'h0;
          else if (tmr_reg == 16'(IFG_CYCLES - 1))
          begin
            tx_state_reg <= TX_SEND;
            tmr_reg      <= 16'h0;
          end
          else
            tmr_reg <= tmr_reg + 16'h1;
        TX_SEND:
          if (tx_done)
            tx_state_reg <= TX_IDLE;
          else if (!full_dup && col_s2)
          begin
            tx_state_reg <= TX_JAM;
            tmr_reg      <= 16'h0;
          end
        TX_JAM:
          if (tmr_reg == 16'(JAM_CYCLES - 1))
          begin
            tx_state_reg <= TX_BACKOFF;
            tmr_reg      <= 16'h0;
            slots_reg    <= lfsr_reg[9:0] & bo_mask;
            if (attempt_reg != 4'hF)
              attempt_reg <= attempt_reg + 4'h1;
          end
          else
            tmr_reg <= tmr_reg + 16'h1;
        TX_BACKOFF:
          if (slots_reg == 10'h0)
            tx_state_reg <= TX_DEFER;
          else if (tmr_reg == 16'(SLOT_CYCLES - 1))
          begin
            tmr_reg   <= 16'h0;
            slots_reg <= slots_reg - 10'h1;
          end
          else
            tmr_reg <= tmr_reg + 16'h1;
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      {tx_grant, tx_jam, tx_backoff} <= 3'h0;
    else
    begin
      tx_grant   <= tx_state_reg == TX_SEND;
      tx_jam     <= tx_state_reg == TX_JAM;
      tx_backoff <= tx_state_reg == TX_BACKOFF;
    end
  end

  // AXI4-Lite slave
  logic              aw_have_reg, w_have_reg, aw_have_next, w_have_next, wr_fire;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              rvalid_next, rd_ok;
  logic [DATA_W-1:0] rd_word;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    return r;
  endfunction

  assign wr_fire      = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign aw_have_next = wr_fire ? 1'b0 : (s_axi_awvalid && s_axi_awready) || aw_have_reg;
  assign w_have_next  = wr_fire ? 1'b0 : (s_axi_wvalid && s_axi_wready) || w_have_reg;
  assign rvalid_next  = (s_axi_arvalid && s_axi_arready)
                      || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {aw_have_reg, w_have_reg, s_axi_awready, s_axi_wready} <= 4'h0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      aw_have_reg   <= aw_have_next;
      w_have_reg    <= w_have_next;
      s_axi_awready <= !aw_have_next;
      s_axi_wready  <= !w_have_next;
      if (s_axi_awvalid && s_axi_awready)
        aw_addr_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  logic        wr_in_list;
  logic [ADDR_W-1:0] wr_off;
  assign wr_off     = aw_addr_reg - REG_MCAST_BASE;
  assign wr_in_list = aw_addr_reg >= REG_MCAST_BASE
                   && wr_off < ADDR_W'(MCAST_ENTRIES * 8);

  // Writes to the read-only counters are answered but change nothing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reg        <= CTRL_RESET;
      mac_reg         <= MAC_RESET;
      max_len_reg     <= MAX_LEN_RESET;
      mcast_valid_reg <= '0;
      for (int i = 0; i < MCAST_ENTRIES; i++)
        mcast_reg[i] <= 48'h0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if (aw_addr_reg == REG_CTRL)
          ctrl_reg <= 2'(merge({30'h0, ctrl_reg}, w_data_reg, w_strb_reg));
        else if (aw_addr_reg == REG_MAC_LO)
          mac_reg[31:0] <= merge(mac_reg[31:0], w_data_reg, w_strb_reg);
        else if (aw_addr_reg == REG_MAC_HI)
          mac_reg[47:32] <= 16'(merge({16'h0, mac_reg[47:32]}, w_data_reg, w_strb_reg));
        else if (aw_addr_reg == REG_MAX_LEN)
          max_len_reg <= 16'(merge({16'h0, max_len_reg}, w_data_reg, w_strb_reg));
        else if (wr_in_list)
        begin
          for (int i = 0; i < MCAST_ENTRIES; i++)
            if (wr_off[ADDR_W-1:3] == (ADDR_W-3)'(i))
            begin
              if (!wr_off[2])
                mcast_reg[i][31:0] <= merge(mcast_reg[i][31:0], w_data_reg, w_strb_reg);
              else
                {mcast_valid_reg[i], mcast_reg[i][47:32]} <=
                  17'(merge({15'h0, mcast_valid_reg[i], mcast_reg[i][47:32]},
                            w_data_reg, w_strb_reg));
            end
        end
        else if (aw_addr_reg != REG_START_OVR && aw_addr_reg != REG_MIDDLE_OVR
                 && aw_addr_reg != REG_DESC_OVR && aw_addr_reg != REG_STATUS)
          s_axi_bresp <= RESP_SLVERR;
      end
    end
  end

  logic [ADDR_W-1:0] rd_off;
  assign rd_off = s_axi_araddr - REG_MCAST_BASE;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = '0;
    case (s_axi_araddr)
      REG_START_OVR:  rd_word = start_cnt;
      REG_MIDDLE_OVR: rd_word = mid_cnt;
      REG_DESC_OVR:   rd_word = desc_cnt;
      REG_CTRL:       rd_word = {30'h0, ctrl_reg};
      REG_STATUS:     rd_word = {20'h0, is_mcast, is_bcast, accept, attempt_reg,
                                 tx_state_reg, rx_state_reg};
      REG_MAC_LO:     rd_word = mac_reg[31:0];
      REG_MAC_HI:     rd_word = {16'h0, mac_reg[47:32]};
      REG_MAX_LEN:    rd_word = {16'h0, max_len_reg};
      default:
      begin
        rd_ok = 1'b0;
        for (int i = 0; i < MCAST_ENTRIES; i++)
          if (s_axi_araddr >= REG_MCAST_BASE && rd_off[ADDR_W-1:3] == (ADDR_W-3)'(i))
          begin
            rd_ok   = 1'b1;
            rd_word = rd_off[2] ? {15'h0, mcast_valid_reg[i], mcast_reg[i][47:32]}
                                : mcast_reg[i][31:0];
          end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid  <= rvalid_next;
      s_axi_arready <= !rvalid_next;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule

// file: ros_top_monitor.sv
// Port checker for the overrun statistics block
`timescale 1ns/1ns
module ros_top_monitor
  import ros_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // Register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Transmit
  input wire logic              tx_grant,
  input wire logic              tx_jam,
  input wire logic              tx_backoff
);
  logic [7:0] jam_reg;

  // Length of the current jam run
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      jam_reg <= 8'h00;
    else
      jam_reg <= tx_jam ? jam_reg + 8'h01 : 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence jam_run;
    tx_jam [*8];
  endsequence

  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  write_answer_a:
    assert property (w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  read_release_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read not released");
  jam_start_a:
    assert property ($rose(tx_jam) |-> $past(tx_grant) ##1 jam_run)
    else $error("jam without send");
  jam_length_a:
    assert property ($fell(tx_jam) |-> jam_reg == 8'(JAM_CYCLES))
    else $error("jam length wrong");
  tx_excl_a:
    assert property ($onehot0({tx_grant, tx_jam, tx_backoff}))
    else $error("send jam backoff overlap");
endmodule

bind ros_top ros_top_monitor u_mon (.*);

// file: ros_phy_model.sv
// Far-side transceiver model with buffer pressure
`timescale 1ns/1ns
module ros_phy_model
  import ros_pkg::*;
(
  // Receive pins
  output logic        mii_rx_clk,
  output ros_mii_rx_t mii_rx,
  output logic        mii_crs,
  output logic        mii_col,
  // Buffer pressure in step with frames
  output ros_rsrc_t   rsrc
);
  initial
  begin
    mii_rx_clk = 1'h0;
    mii_rx = '0;
    mii_crs = 1'h0;
    mii_col = 1'h0;
    rsrc = 3'h2;
  end
  // Released data flips so a stale nibble never looks valid
  task automatic nib(input logic v, input logic e, input logic [3:0] d);
    mii_rx.dv = v;
    mii_rx.er = e;
    mii_rx.d = v ? d : ~mii_rx.d;
    mii_crs = v;
    #20 mii_rx_clk = 1'h1;
    #20 mii_rx_clk = 1'h0;
  endtask
  // Clock stands still between frames
  task automatic frame(input logic [47:0] da, input int n, input logic e,
                       input ros_rsrc_t st, input ros_rsrc_t md);
    #1 rsrc = st;
    for (int i = 0; i < 7; i++) nib(1'h1, 1'h0, 4'h5);
    nib(1'h1, 1'h0, SFD_NIBBLE);
    for (int i = 0; i < 12; i++) nib(1'h1, 1'h0, da[4*i+:4]);
    for (int i = 0; i < n; i++)
    begin
      if (i == 2) rsrc = md;
      nib(1'h1, e, i[3:0]);
    end
    nib(1'h0, 1'h0, 4'h0);
    rsrc = 3'h2;
  endtask
  task automatic line(input logic c, input logic k);
    mii_crs <= c;
    mii_col <= k;
  endtask
endmodule

// file: ros_top_tb.sv
// Self-checking bench of the overrun statistics block
`timescale 1ns/1ns
module ros_top_tb
  import ros_pkg::*;
;
  localparam logic [47:0] MAC = 48'h0A0908070602, OTH = 48'h0A0908070604;
  localparam logic [47:0] GRP = 48'h060504030201, UNL = 48'h060504030211;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
  localparam ros_rsrc_t OK = 3'h2, FUL = 3'h6, NOB = 3'h0, HDZ = 3'h3;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, mii_rx_clk, mii_crs, mii_col;
  logic              tx_req, tx_done, tx_grant, tx_jam, tx_backoff;
  ros_mii_rx_t       mii_rx;
  ros_rsrc_t         rsrc;
  int                num_errors, compares;
  logic [31:0]       es, em, ed;

  ros_top DUT (.*);
  ros_phy_model phy (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t;
    aw_t = 1'h0;
    w_t = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_t && w_t))
    begin
      @(posedge clk);
      aw_t |= s_axi_awready;
      w_t |= s_axi_wready;
      s_axi_awvalid <= !aw_t;
      s_axi_wvalid <= !w_t;
    end
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  // Expected totals run across all frames, counters never clear
  task automatic fr(input logic [47:0] da, input int n, input logic e,
                    input ros_rsrc_t st, input ros_rsrc_t md, input logic [2:0] x);
    phy.frame(da, n, e, st, md);
    repeat (12) @(posedge clk);
    es += 32'(x[2]);
    em += 32'(x[1]);
    ed += 32'(x[0]);
    rd(REG_START_OVR, es, RESP_OKAY);
    rd(REG_MIDDLE_OVR, em, RESP_OKAY);
    rd(REG_DESC_OVR, ed, RESP_OKAY);
  endtask
  task automatic go(output int n);
    n = 0;
    while (tx_grant !== 1'h1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    rd(REG_MAX_LEN, 32'(MAX_LEN_RESET), RESP_OKAY);
    rd(8'hF0, 32'h0, RESP_SLVERR);
    wr(8'hF0, 32'h1, RESP_SLVERR);
    wr(REG_START_OVR, 32'h5, RESP_OKAY);
    rd(REG_START_OVR, 32'h0, RESP_OKAY);
    wr(REG_MAX_LEN, 32'h40, RESP_OKAY);
    rd(REG_MAX_LEN, 32'h40, RESP_OKAY);
  endtask
  task automatic t_frames();
    wr(REG_MAC_LO, MAC[31:0], RESP_OKAY);
    wr(REG_MAC_HI, {16'h0, MAC[47:32]}, RESP_OKAY);
    wr(REG_MCAST_BASE, GRP[31:0], RESP_OKAY);
    wr(REG_MCAST_BASE + 8'h04, {15'h0, 1'h1, GRP[47:32]}, RESP_OKAY);
    fr(MAC, 20, 1'h0, OK, OK, 3'h0);
    fr(MAC, 20, 1'h0, FUL, OK, 3'h4);
    fr(MAC, 20, 1'h0, OK, NOB, 3'h2);
    fr(MAC, 20, 1'h0, HDZ, OK, 3'h5);
    fr(MAC, 20, 1'h0, OK, HDZ, 3'h3);
    fr(MAC, 20, 1'h0, FUL, NOB, 3'h4);
    fr(MAC, 20, 1'h0, OK, FUL, 3'h2);
    fr(OTH, 20, 1'h0, FUL, OK, 3'h0);
    fr(BC, 20, 1'h0, FUL, OK, 3'h4);
    fr(GRP, 20, 1'h0, FUL, OK, 3'h4);
    fr(UNL, 20, 1'h0, FUL, OK, 3'h0);
    fr(MAC, 20, 1'h1, FUL, OK, 3'h4);
    fr(MAC, 20, 1'h1, OK, OK, 3'h0);
    fr(MAC, 4, 1'h0, FUL, OK, 3'h4);
    fr(MAC, 200, 1'h0, OK, NOB, 3'h2);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    fr(OTH, 20, 1'h0, FUL, OK, 3'h4);
    fr(UNL, 20, 1'h0, FUL, OK, 3'h4);
  endtask
  task automatic t_full();
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    phy.line(1'h1, 1'h1);
    tx_req <= 1'h1;
    repeat (4) @(posedge clk);
    chk({tx_grant, tx_jam}, 32'h2);
    tx_req <= 1'h0;
    tx_done <= 1'h1;
    @(posedge clk);
    tx_done <= 1'h0;
    repeat (3) @(posedge clk);
    chk(tx_grant, 32'h0);
  endtask
  task automatic t_half();
    int n;
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    tx_req <= 1'h1;
    phy.line(1'h1, 1'h0);
    repeat (200) @(posedge clk);
    chk(tx_grant, 32'h0);
    phy.line(1'h0, 1'h0);
    go(n);
    chk(n > IFG_CYCLES && n < IFG_CYCLES + 9, 32'h1);
    tx_req <= 1'h0;
    phy.line(1'h0, 1'h1);
    repeat (8) @(posedge clk);
    phy.line(1'h0, 1'h0);
    chk(tx_jam, 32'h1);
    go(n);
    chk(tx_grant === 1'h1 && n > JAM_CYCLES + IFG_CYCLES - 8, 32'h1);
    tx_done <= 1'h1;
    @(posedge clk);
    tx_done <= 1'h0;
  endtask
  task automatic final_report();
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // Whole run needs about 6k cycles
  initial
  begin
    #400000;
    num_errors++;
    final_report();
  end
  initial
  begin
    {num_errors, compares, es, em, ed} = '0;
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, tx_req, tx_done, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    t_regs();
    t_frames();
    t_full();
    t_half();
    final_report();
  end
endmodule
